// file: common/jtag_bridge_pkg.sv
// constants shared by the bus-to-scan-chain bridge
// assumes a four-bit processor data bus and an eight-bit address bus
package jtag_bridge_pkg;
	localparam int          DATA_W      = 4;
	localparam int          ADDR_W      = 8;
	localparam logic [7:0]  CHAIN_ADDR  = 8'h40;
	// data bus bit positions
	localparam int          BIT_TCK     = 0;
	localparam int          BIT_TMS     = 1;
	localparam int          BIT_TDI     = 2;
	localparam int          BIT_TDO     = 3;
	// register reset values
	localparam logic        RST_TCK     = 1'b0;
	localparam logic        RST_TMS     = 1'b1;
	localparam logic        RST_TDI     = 1'b0;
endpackage

// file: common/chain_xfer_if.sv
// carrier between the processor-bus end and the system-clock core
// toggle handshake for writes, per-bit levels for readback
`timescale 1ns/1ns
`default_nettype none
interface chain_xfer_if;
	logic       wr_toggle;
	logic [2:0] wr_bits;
	logic       ack_toggle;
	logic [3:0] state_bits;
	modport bus_end (
		output wr_toggle,
		output wr_bits,
		input  ack_toggle,
		input  state_bits
	);
	modport core_end (
		input  wr_toggle,
		input  wr_bits,
		output ack_toggle,
		output state_bits
	);
endinterface
`default_nettype wire

// file: rtl/chain_bus_end.sv
// processor bus end of the bridge, clocked by the processor clock
// assumes address, strobe and direction are synchronous to i_bus_clock
`timescale 1ns/1ns
`default_nettype none
module chain_bus_end
	import jtag_bridge_pkg::*;
(
	// clock and reset
	input  wire logic              i_bus_clock,
	input  wire logic              i_rst_n,
	// processor bus
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic              i_bus_access_strobe,
	input  wire logic              i_read_not_write_select,
	input  wire logic [DATA_W-1:0] i_data,
	output logic      [DATA_W-1:0] o_data,
	output logic                   o_data_oe_n,
	// toward the core
	chain_xfer_if.bus_end          xfer
);
	logic       wr_toggle;
	logic [2:0] wr_bits;
	logic       prev_wr;
	logic [1:0] ack_sync;
	logic [3:0] st_meta;
	logic [3:0] st_sync;
	logic       next_wr_toggle;
	logic [2:0] next_wr_bits;
	logic       hit;
	logic       wr_hit;
	logic       pending;

	assign hit    = i_bus_access_strobe && (i_addr == CHAIN_ADDR);
	assign wr_hit = hit && !i_read_not_write_select;
	// a write arriving while the last one is still in flight is dropped
	assign pending = wr_toggle != ack_sync[1];

	always_comb begin
		next_wr_toggle = wr_toggle;
		next_wr_bits   = wr_bits;
		if (wr_hit && !prev_wr && !pending) begin
			next_wr_bits[BIT_TCK] = i_data[BIT_TCK];
			next_wr_bits[BIT_TMS] = i_data[BIT_TMS];
			next_wr_bits[BIT_TDI] = i_data[BIT_TDI];
			next_wr_toggle        = ~wr_toggle;
		end
	end

	always_ff @(posedge i_bus_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_toggle <= 1'b0;
			wr_bits   <= 3'h0;
			prev_wr   <= 1'b0;
			ack_sync  <= 2'h0;
			st_meta   <= 4'h0;
			st_sync   <= 4'h0;
		end else begin
			wr_toggle <= next_wr_toggle;
			wr_bits   <= next_wr_bits;
			prev_wr   <= wr_hit;
			ack_sync  <= {ack_sync[0], xfer.ack_toggle};
			st_meta   <= xfer.state_bits;
			st_sync   <= st_meta;
		end
	end

	assign xfer.wr_toggle = wr_toggle;
	assign xfer.wr_bits   = wr_bits;
	// tdo and register readback, driven only during a decoded read
	assign o_data      = st_sync;
	assign o_data_oe_n = !(hit && i_read_not_write_select);
endmodule
`default_nettype wire

// file: rtl/jtag_bitbang_bridge.sv
// top of the processor-bus to scan-chain bridge
// assumes tdo and cable pins are asynchronous to i_clock
// assumes i_bus_clock is unrelated to i_clock; writes cross by toggle
// What this block does
// - tms, tck and tdi leave only from flip-flops on the system clock.
// - a cable select hands the chain lines to a download cable.
// - only the data bus is essential; address and strobes just decode.
// - a decoded write loads three flip-flops from the data bus.
// - a decoded read drives tdo onto the bus; otherwise bus released.
// - reads also return the current tdi, tms and tck register values.
// - the chain occupies one bus address, reached by reads and writes.
`timescale 1ns/1ns
`default_nettype none
module jtag_bitbang_bridge
	import jtag_bridge_pkg::*;
(
	// system clock and reset
	input  wire logic              i_clock,
	input  wire logic              i_rst_n,
	// processor bus, on the processor clock
	input  wire logic              i_bus_clock,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic              i_bus_access_strobe,
	input  wire logic              i_read_not_write_select,
	input  wire logic [DATA_W-1:0] i_data,
	output logic      [DATA_W-1:0] o_data,
	output logic                   o_data_oe_n,
	// download cable
	input  wire logic              i_cable_select,
	input  wire logic              i_cable_tck,
	input  wire logic              i_cable_tms,
	input  wire logic              i_cable_tdi,
	output logic                   o_cable_tdo,
	// scan chain
	output logic                   o_tck,
	output logic                   o_tms,
	output logic                   o_tdi,
	input  wire logic              i_tdo
);
	chain_xfer_if xfer ();

	chain_bus_end u_bus_end (
		.i_bus_clock             (i_bus_clock),
		.i_rst_n                 (i_rst_n),
		.i_addr                  (i_addr),
		.i_bus_access_strobe     (i_bus_access_strobe),
		.i_read_not_write_select (i_read_not_write_select),
		.i_data                  (i_data),
		.o_data                  (o_data),
		.o_data_oe_n             (o_data_oe_n),
		.xfer                    (xfer.bus_end)
	);

	// decoding helpers, each applied to all three chain lines
	// one written bit by its bus position
	function automatic logic wr_field(
		input logic [2:0] bits,
		input int         pos
	);
		return bits[pos];
	endfunction

	// cable or processor value for one chain line
	function automatic logic line_pick(
		input logic sel_cable,
		input logic cable_val,
		input logic own_val
	);
		return sel_cable ? cable_val : own_val;
	endfunction

	// asynchronous pins gathered for one two-stage crossing
	// limitation: a cable pulse shorter than one cycle may be lost
	localparam int PIN_W   = DATA_W + 1;
	localparam int PIN_SEL = DATA_W;

	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_sync;
	logic             cable_mode;
	logic             tdo_s;

	assign pin_raw[BIT_TCK] = i_cable_tck;
	assign pin_raw[BIT_TMS] = i_cable_tms;
	assign pin_raw[BIT_TDI] = i_cable_tdi;
	assign pin_raw[BIT_TDO] = i_tdo;
	assign pin_raw[PIN_SEL] = i_cable_select;

	genvar gi;
	generate
		for (gi = 0; gi < PIN_W; gi = gi + 1) begin : g_pin_sync
			// first stage feeds only the second
			logic meta;
			logic synced;
			// reset to 0 so a missing cable reads as deselected
			always_ff @(posedge i_clock or negedge i_rst_n) begin
				if (!i_rst_n) begin
					meta   <= 1'b0;
					synced <= 1'b0;
				end else begin
					meta   <= pin_raw[gi];
					synced <= meta;
				end
			end
			assign pin_sync[gi] = synced;
		end
	endgenerate

	// each pin is an independent level, so per-bit crossing is enough
	assign cable_mode = pin_sync[PIN_SEL];
	assign tdo_s      = pin_sync[BIT_TDO];

	// write request: the toggle passes three flops before the edge
	// detector; wr_bits cannot move meanwhile, the bus end holds it
	// a toggle rather than a pulse survives any ratio of the two clocks
	logic [1:0] req_meta;
	logic       req_sync;
	logic       req_seen;
	logic       req_edge;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			req_meta <= 2'h0;
			req_sync <= 1'b0;
			req_seen <= 1'b0;
		end else begin
			req_meta <= {req_meta[0], xfer.wr_toggle};
			req_sync <= req_meta[1];
			req_seen <= req_sync;
		end
	end

	assign req_edge = req_sync != req_seen;

	// processor-written registers; they keep loading in cable mode so the
	// chain returns to the last software value when the cable lets go
	logic reg_tck;
	logic reg_tms;
	logic reg_tdi;

	logic next_reg_tck;
	logic next_reg_tms;
	logic next_reg_tdi;

	always_comb begin
		next_reg_tck = reg_tck;
		next_reg_tms = reg_tms;
		next_reg_tdi = reg_tdi;
		// cable mode does not block loads
		if (req_edge) begin
			next_reg_tck = wr_field(xfer.wr_bits, BIT_TCK);
			next_reg_tms = wr_field(xfer.wr_bits, BIT_TMS);
			next_reg_tdi = wr_field(xfer.wr_bits, BIT_TDI);
		end
	end

	// reset values keep tck low until software takes over
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			reg_tck <= RST_TCK;
			reg_tms <= RST_TMS;
			reg_tdi <= RST_TDI;
		end else begin
			reg_tck <= next_reg_tck;
			reg_tms <= next_reg_tms;
			reg_tdi <= next_reg_tdi;
		end
	end

	// chain line flops; the selector sits in front of them so the lines
	// never glitch when ownership changes
	logic tck;
	logic tms;
	logic tdi;
	logic cable_tdo;

	logic next_tck;
	logic next_tms;
	logic next_tdi;
	logic next_cable_tdo;

	// trade-off: cable edges arrive three cycles late but never glitch
	always_comb begin
		// cable timing is resampled, adding up to three cycles of skew
		next_tck       = line_pick(cable_mode, pin_sync[BIT_TCK],
			next_reg_tck);
		next_tms       = line_pick(cable_mode, pin_sync[BIT_TMS],
			next_reg_tms);
		next_tdi       = line_pick(cable_mode, pin_sync[BIT_TDI],
			next_reg_tdi);
		next_cable_tdo = tdo_s;
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tck       <= RST_TCK;
			tms       <= RST_TMS;
			tdi       <= RST_TDI;
			cable_tdo <= 1'b0;
		end else begin
			tck       <= next_tck;
			tms       <= next_tms;
			tdi       <= next_tdi;
			cable_tdo <= next_cable_tdo;
		end
	end

	// ack even in cable mode so the bus end never stalls
	assign xfer.ack_toggle = req_seen;
	// readback shows the registers, not the lines, which differ in cable mode
	assign xfer.state_bits = {tdo_s, reg_tdi, reg_tms,
		reg_tck};
	// chain and cable outputs come straight from flops
	assign o_tck       = tck;
	assign o_tms       = tms;
	assign o_tdi       = tdi;
	assign o_cable_tdo = cable_tdo;
endmodule
`default_nettype wire

// file: test/jtag_bridge_properties.sv
// checks on the bridge ports, sampled on the bus clock
// assumes bench inputs move just after bus clock edges
`timescale 1ns/1ns
`default_nettype none
module jtag_bridge_properties
	import jtag_bridge_pkg::*;
(
	input wire logic		i_bus_clock,
	input wire logic		i_rst_n,
	input wire logic [ADDR_W-1:0]	i_addr,
	input wire logic		i_bus_access_strobe,
	input wire logic		i_read_not_write_select,
	input wire logic [DATA_W-1:0]	i_data,
	input wire logic [DATA_W-1:0]	o_data,
	input wire logic		o_data_oe_n,
	input wire logic		i_cable_select,
	input wire logic		i_cable_tck,
	input wire logic		o_tck,
	input wire logic		o_tms,
	input wire logic		o_tdi,
	input wire logic		i_tdo
);
	logic [2:0] wr;
	wire logic hit = i_bus_access_strobe && i_addr == CHAIN_ADDR;
	wire logic rd = hit && i_read_not_write_select;
	wire logic wh = hit && !i_read_not_write_select;
	wire logic [3:0] st = {i_tdo, o_tdi, o_tms, o_tck};
	always_ff @(posedge i_bus_clock) wr <= wh ? i_data[2:0] : wr;
	default clocking cb @(posedge i_bus_clock); endclocking
	default disable iff (!i_rst_n);
	chk_rst_lines: assert property ($rose(i_rst_n) |->
		st[2:0] == {RST_TDI, RST_TMS, RST_TCK}) else $error("reset lines");
	chk_rd_drive: assert property (rd |-> !o_data_oe_n)
		else $error("read not driven");
	chk_bus_idle: assert property (!rd |-> o_data_oe_n)
		else $error("bus driven");
	chk_wr_load: assert property (
		$rose(wh) && !i_cable_select |=> st[2:0] == wr) else $error("no load");
	// a write lands well inside one bus cycle, so three quiet ones settle
	chk_lines_hold: assert property (
		(!i_cable_select && !wh)[*3] |-> $stable(st[2:0]))
		else $error("lines moved");
	chk_rd_tdo: assert property ($stable(st)[*4] ##0 rd |->
		o_data[BIT_TDO] == i_tdo) else $error("bad tdo read");
	// readback shows the registers, which match the lines only off cable
	chk_rd_back: assert property (
		($stable(st) && !i_cable_select)[*4] ##0 rd |->
		o_data[2:0] == st[2:0]) else $error("bad readback");
	chk_cable_fwd: assert property (i_cable_select[*3] |->
		o_tck == i_cable_tck) else $error("cable not forwarded");
endmodule
bind jtag_bitbang_bridge jtag_bridge_properties i_props (.*);
`default_nettype wire

// file: test/cpu_bus_model.sv
// processor bus master model, one access per call
// assumes reads are answered in the cycle they are presented
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_model
	import jtag_bridge_pkg::*;
(
	input wire logic		i_bus_clock,
	input wire logic [DATA_W-1:0]	i_rdata,
	input wire logic		i_oe_n,
	output logic [ADDR_W-1:0]	o_addr,
	output logic			o_strobe,
	output logic			o_rnw,
	output logic [DATA_W-1:0]	o_wdata
);
	initial {o_addr, o_strobe, o_rnw, o_wdata} = '0;
	task automatic acc(input logic [ADDR_W-1:0] a, input logic r,
		input logic [DATA_W-1:0] d, output logic [4:0] q);
		@(posedge i_bus_clock) #1;
		{o_addr, o_strobe, o_rnw, o_wdata} = {a, 1'b1, r, d};
		@(posedge i_bus_clock) q = {i_oe_n, i_rdata};
		// idle lines show no stale address or data
		#1 {o_addr, o_strobe, o_wdata} = {~a, 1'b0, ~d};
	endtask
endmodule
`default_nettype wire

// file: test/tb.sv
// bench: processor model drives the chain, then the cable takes over
// assumes unrelated clocks and reset held 12 cycles
`timescale 1ns/1ns
`default_nettype none
module tb
	import jtag_bridge_pkg::*;
;
	logic		i_clock = 0, i_bus_clock = 0, i_rst_n = 0, i_tdo = 0;
	logic		i_cable_select = 0, i_cable_tck = 0, i_cable_tms = 0;
	logic		i_cable_tdi = 0, i_bus_access_strobe, o_data_oe_n;
	logic		i_read_not_write_select, o_cable_tdo, o_tck, o_tms, o_tdi;
	logic [ADDR_W-1:0]	i_addr, a;
	logic [DATA_W-1:0]	i_data, o_data, d;
	logic [4:0]	q;
	int		err_count = 0, checks_done = 0, exp;
	jtag_bitbang_bridge i_jtag_bitbang_bridge (.*);
	cpu_bus_model i_cpu_bus_model (.i_bus_clock, .i_rdata(o_data),
		.i_oe_n(o_data_oe_n), .o_addr(i_addr), .o_strobe(i_bus_access_strobe),
		.o_rnw(i_read_not_write_select), .o_wdata(i_data));
	function automatic logic [4:0] lines();
		return {1'b0, o_cable_tdo, o_tdi, o_tms, o_tck};
	endfunction
	task automatic compare(input string n, input logic [4:0] e, g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// cable pins move in both modes so the selector is exercised
	task automatic jiggle;
		{i_cable_tdi, i_cable_tms, i_cable_tck, i_tdo} = 4'($urandom);
	endtask
	initial forever #5 i_clock = ~i_clock;
	initial #3 forever #40 i_bus_clock = ~i_bus_clock;
	initial #200000 begin
		err_count++;
		wrap_up;
	end
	initial begin
		exp = {RST_TDI, RST_TMS, RST_TCK};
		void'($urandom(56));
		repeat (12) @(posedge i_clock);
		#1 i_rst_n = 1;
		compare("reset", 5'(exp), lines());
		repeat (30) begin
			a = ($urandom % 2) ? CHAIN_ADDR : ADDR_W'($urandom);
			d = DATA_W'($urandom);
			@(posedge i_bus_clock) #1 jiggle;
			i_cpu_bus_model.acc(a, 1'b0, d, q);
			if (a == CHAIN_ADDR) exp = d[2:0];
			repeat (4) @(posedge i_bus_clock);
			compare("lines", {1'b0, i_tdo, 3'(exp)}, lines());
			i_cpu_bus_model.acc(CHAIN_ADDR, 1'b1, d, q);
			compare("read", {1'b0, i_tdo, 3'(exp)}, q);
		end
		@(posedge i_bus_clock) #1 i_cable_select = 1;
		repeat (10) begin
			@(posedge i_bus_clock) #1;
			compare("cable", {1'b0, i_tdo, i_cable_tdi, i_cable_tms,
				i_cable_tck}, lines());
			jiggle;
		end
		d = DATA_W'(~exp);
		i_cpu_bus_model.acc(CHAIN_ADDR, 1'b0, d, q);
		// registers still load under the cable; the lines stay the cable's
		exp = d[2:0];
		repeat (4) @(posedge i_bus_clock);
		i_cpu_bus_model.acc(CHAIN_ADDR, 1'b1, d, q);
		compare("held", {1'b0, i_tdo, 3'(exp)}, q);
		i_cable_select = 0;
		repeat (2) @(posedge i_bus_clock);
		compare("back", {1'b0, i_tdo, 3'(exp)}, lines());
		wrap_up;
	end
endmodule
`default_nettype wire
